// ==== rtl/two_wire_audio_switch_control.sv ====
// Purpose: Two-wire slave that opens, closes and sets modes of 14 switches.
// Assumes: SCL and SDA are slow against the 100 MHz core clock.
// Notes:   Commands apply only at their executing acknowledge clock edge.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Each switch keeps its own soft or hard transition mode bit.
// - Soft switches ramp slowly; hard switches change at once.
// - A new command first finishes any soft transition still running.
// - After power-up every switch is in soft mode.
// - Same-mode switches break before make; different modes are unordered.
// - A double-throw selector is two independently controlled single throws.
// - Switch-state data: 1 closes a switch, 0 opens it.
// - Mode-select data: 1 sets hard mode, 0 sets soft mode.
// - Reset command opens all switches and sets all to soft mode.
// - First byte is address; answer only on pin and pattern match.
// - Low select pin is address bit one, high pin is bit two.
// - Byte after address is the command byte.
// - Reset executes at the rising clock of its acknowledge bit.
// - First data byte is held, so all switches update together.
// - Mode and switch commands execute at the second data acknowledge.
// - All bytes arrive most significant bit first.
// - Device only receives; it never starts a transfer.
// - Start is SDA falling with SCL high; always watched for.
// - On own address, device holds SDA low for the acknowledge clock.
// - Command and data bytes are acknowledged as well.
// - Command top bits: 00 reset, 01 mode, 10 nothing, 11 switch.
// - Data bits D0 upward map one per switch across fourteen bits.
// - Stop is SDA rising with SCL high and frees the bus.
module two_wire_audio_switch_control
   import audio_switch_pkg::*;
#(
   parameter int ON_STEP  = audio_switch_pkg::ON_STEP_CYC,
   parameter int OFF_STEP = audio_switch_pkg::OFF_STEP_CYC
) (
   input  wire logic                               core_clk_i,
   input  wire logic                               rst_i,
   input  wire logic                               scl_i,
   input  wire logic                               sda_i,
   input  wire logic                               addr_select_low_i,
   input  wire logic                               addr_select_high_i,
   output logic                                    sda_o,
   output logic                                    sda_oe_o,
   output logic [audio_switch_pkg::NUM_SW*audio_switch_pkg::LVL_W-1:0] sw_level_o,
   output logic [audio_switch_pkg::NUM_SW-1:0]     sw_closed_o,
   output logic [audio_switch_pkg::NUM_SW-1:0]     sw_hard_o,
   output logic                                    busy_o,
   output logic                                    cmd_exec_o
);

   import audio_switch_pkg::*;

   // ==========================================================
   // Pin synchronisation and bus event detection.
   pin_s pins_raw;
   pin_s pins;
   logic scl_q;
   logic sda_q;

   assign pins_raw = {scl_i, sda_i, addr_select_high_i, addr_select_low_i};

   pin_sync #(
      .W ($bits(pin_s))
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    (pins_raw),
      .sync_o     (pins)
   );

   // Previous synced levels give edges on the core clock.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end else begin
         scl_q <= pins.scl;
         sda_q <= pins.sda;
      end
   end

   // Start and stop only count while SCL stays high over both samples.
   wire scl_rise  = pins.scl && !scl_q;
   wire scl_fall  = !pins.scl && scl_q;
   wire scl_hold  = pins.scl && scl_q;
   wire start_det = scl_hold && sda_q && !pins.sda;
   wire stop_det  = scl_hold && !sda_q && pins.sda;

   // ==========================================================
   // Receiver state.
   rx_state_e         st_q;
   rx_state_e         st_d;
   logic [3:0]        bit_q;
   logic [3:0]        bit_d;
   logic [7:0]        shreg_q;
   logic [7:0]        shreg_d;
   logic              ack_q;
   logic              ack_d;
   logic [1:0]        cmd_q;
   logic [1:0]        cmd_d;
   logic [7:0]        hold_q;
   logic [7:0]        hold_d;
   logic              exec_q;
   logic              exec_d;
   logic [1:0]        exec_cmd_q;
   logic [1:0]        exec_cmd_d;
   logic [NUM_SW-1:0] exec_data_q;
   logic [NUM_SW-1:0] exec_data_d;

   // Address byte fields against the fixed pattern and strap pins.
   wire fix_ok  = shreg_q[ADDR_FIX_MSB:ADDR_FIX_LSB] == ADDR_FIXED;
   wire hi_ok   = shreg_q[ADDR_HI_BIT] == pins.a_hi;
   wire lo_ok   = shreg_q[ADDR_LO_BIT] == pins.a_lo;
   wire rw_ok   = shreg_q[ADDR_RW_BIT] == ADDR_WRITE;
   wire addr_ok = fix_ok && hi_ok && lo_ok && rw_ok;

   // Command code and the fourteen-bit data word from both data bytes.
   wire [1:0] rx_cmd = shreg_q[CMD_MSB:CMD_LSB];
   wire [NUM_SW-1:0] rx_word = {hold_q[DATA1_BITS-1:0], shreg_q};

   // Which byte slots get an acknowledge; a finished word gets none.
   wire in_data  = (st_q == ST_CMD) || (st_q == ST_DATA1) || (st_q == ST_DATA2);
   wire want_ack = ((st_q == ST_ADDR) && addr_ok) || in_data;

   // ==========================================================
   // Byte and acknowledge sequencing.
   always_comb begin
      st_d        = st_q;
      bit_d       = bit_q;
      shreg_d     = shreg_q;
      ack_d       = ack_q;
      cmd_d       = cmd_q;
      hold_d      = hold_q;
      exec_d      = 1'h0;
      exec_cmd_d  = exec_cmd_q;
      exec_data_d = exec_data_q;
      if (start_det) begin
         // A repeated start drops any partial command unexecuted.
         st_d  = ST_ADDR;
         bit_d = '0;
         ack_d = 1'h0;
      end else if (stop_det) begin
         st_d  = ST_IDLE;
         bit_d = '0;
         ack_d = 1'h0;
      end else if (st_q == ST_IDLE) begin
         // Receive only: nothing happens until a master starts.
         bit_d = '0;
      end else if (scl_rise && (bit_q < BIT_ACK)) begin
         shreg_d = {shreg_q[6:0], pins.sda};
         bit_d   = bit_q + 4'h1;
      end else if (scl_fall && (bit_q == BIT_ACK)) begin
         ack_d = want_ack;
      end else if (scl_rise && (bit_q == BIT_ACK)) begin
         bit_d = BIT_POST;
         if (!ack_q) begin
            if (st_q == ST_ADDR) begin
               st_d = ST_IGNORE;
            end
         end else begin
            unique case (st_q)
               ST_ADDR: begin
                  st_d = ST_CMD;
               end
               ST_CMD: begin
                  cmd_d = rx_cmd;
                  if (rx_cmd == CMD_RESET) begin
                     exec_d     = 1'h1;
                     exec_cmd_d = CMD_RESET;
                     st_d       = ST_DONE;
                  end else begin
                     st_d = ST_DATA1;
                  end
               end
               ST_DATA1: begin
                  hold_d = shreg_q;
                  st_d   = ST_DATA2;
               end
               ST_DATA2: begin
                  exec_d      = 1'h1;
                  exec_cmd_d  = cmd_q;
                  exec_data_d = rx_word;
                  st_d        = ST_DONE;
               end
               default: begin
                  st_d = st_q;
               end
            endcase
         end
      end else if (scl_fall && (bit_q == BIT_POST)) begin
         ack_d = 1'h0;
         bit_d = '0;
      end
   end

   // Receiver registers.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_q        <= ST_IDLE;
         bit_q       <= '0;
         shreg_q     <= '0;
         ack_q       <= 1'h0;
         cmd_q       <= CMD_IDLE;
         hold_q      <= '0;
         exec_q      <= 1'h0;
         exec_cmd_q  <= CMD_IDLE;
         exec_data_q <= '0;
      end else begin
         st_q        <= st_d;
         bit_q       <= bit_d;
         shreg_q     <= shreg_d;
         ack_q       <= ack_d;
         cmd_q       <= cmd_d;
         hold_q      <= hold_d;
         exec_q      <= exec_d;
         exec_cmd_q  <= exec_cmd_d;
         exec_data_q <= exec_data_d;
      end
   end

   // ==========================================================
   // Switch configuration, changed only by an executing command.
   sw_cfg_s cfg_q;
   sw_cfg_s cfg_d;

   always_comb begin
      cfg_d = cfg_q;
      if (exec_q) begin
         unique case (exec_cmd_q)
            CMD_RESET: cfg_d = CFG_RESET;
            CMD_MODE:  cfg_d.hard = exec_data_q;
            CMD_SWSET: cfg_d.closed = exec_data_q;
            CMD_IDLE:  cfg_d = cfg_q;
         endcase
      end
   end

   // Power-up matches the reset command: all open, all soft.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cfg_q <= CFG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // ==========================================================
   // Soft ramp timebases, shared by every switch in soft mode.
   logic [CNT_W-1:0] on_cnt_q;
   logic [CNT_W-1:0] off_cnt_q;
   wire tick_up = (on_cnt_q == CNT_W'(ON_STEP - 1));
   wire tick_dn = (off_cnt_q == CNT_W'(OFF_STEP - 1));

   always_ff @(posedge core_clk_i) begin
      if (rst_i || tick_up) begin
         on_cnt_q <= '0;
      end else begin
         on_cnt_q <= on_cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i || tick_dn) begin
         off_cnt_q <= '0;
      end else begin
         off_cnt_q <= off_cnt_q + CNT_W'(1);
      end
   end

   // ==========================================================
   // Per-switch drivers with break-before-make gating by mode group.
   logic [NUM_SW-1:0] opening;
   logic [NUM_SW-1:0] gate;
   logic [NUM_SW-1:0] moving;
   logic [NUM_SW*LVL_W-1:0] level_all;

   // A closing switch waits while any switch of its own mode still opens.
   wire open_soft = |(opening & ~cfg_q.hard);
   wire open_hard = |(opening & cfg_q.hard);

   genvar g;
   generate
      // Every bit is its own switch, so a selector's two throws stay apart.
      for (g = 0; g < NUM_SW; g++) begin : g_sw
         assign gate[g] = cfg_q.hard[g] ? !open_hard : !open_soft;
         assign moving[g] = cfg_q.closed[g] ?
                            (level_all[g*LVL_W +: LVL_W] != LVL_MAX) :
                            (level_all[g*LVL_W +: LVL_W] != '0);

         switch_ramp u_ramp (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .target_i   (cfg_q.closed[g]),
            .hard_i     (cfg_q.hard[g]),
            .flush_i    (exec_q),
            .gate_i     (gate[g]),
            .tick_up_i  (tick_up),
            .tick_dn_i  (tick_dn),
            .level_o    (level_all[g*LVL_W +: LVL_W]),
            .opening_o  (opening[g])
         );
      end
   endgenerate

   // ==========================================================
   // Registered status outputs and the open-drain data pin.
   logic busy_q;
   logic sda_out_q;

   // Busy shows one cycle after the ramp state it reports; exec shows one cycle before the config changes.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         busy_q    <= 1'h0;
         sda_out_q <= 1'h0;
      end else begin
         busy_q    <= |moving;
         sda_out_q <= 1'h0;
      end
   end

   assign sda_o       = sda_out_q;
   assign sda_oe_o    = ack_q;
   assign sw_level_o  = level_all;
   assign sw_closed_o = cfg_q.closed;
   assign sw_hard_o   = cfg_q.hard;
   assign busy_o      = busy_q;
   assign cmd_exec_o  = exec_q;

endmodule // two_wire_audio_switch_control
`default_nettype wire

// ==== rtl/audio_switch_pkg.sv ====
// Purpose: Shared constants and types for the two-wire switch controller.
// Assumes: 100 MHz core clock; two-wire pins sampled by that clock.
// Notes:   All encodings, field positions, counts and the configuration reset value live here.
package audio_switch_pkg;

   // ==========================================================
   // Switch array and ramp shape.
   localparam int NUM_SW  = 14;
   localparam int LVL_W   = 4;
   localparam logic [LVL_W-1:0] LVL_MAX = 4'hF;
   localparam int CNT_W   = 20;

   // ==========================================================
   // Timing: soft transitions spread over the full ramp.
   localparam int CLK_HZ      = 100_000_000;
   localparam int SOFT_ON_MS  = 8;
   localparam int SOFT_OFF_MS = 3;
   localparam int SOFT_ON_CYC  = SOFT_ON_MS * (CLK_HZ / 1000);
   localparam int SOFT_OFF_CYC = SOFT_OFF_MS * (CLK_HZ / 1000);
   localparam int ON_STEP_CYC  = SOFT_ON_CYC / int'(LVL_MAX);
   localparam int OFF_STEP_CYC = SOFT_OFF_CYC / int'(LVL_MAX);

   // ==========================================================
   // Address byte layout.
   localparam int ADDR_FIX_MSB = 7;
   localparam int ADDR_FIX_LSB = 3;
   localparam int ADDR_HI_BIT  = 2;
   localparam int ADDR_LO_BIT  = 1;
   localparam int ADDR_RW_BIT  = 0;
   localparam logic [4:0] ADDR_FIXED = 5'h0D;
   localparam logic       ADDR_WRITE = 1'h0;

   // ==========================================================
   // Command byte layout and codes.
   localparam int CMD_MSB = 7;
   localparam int CMD_LSB = 6;
   localparam logic [1:0] CMD_RESET = 2'h0;
   localparam logic [1:0] CMD_MODE  = 2'h1;
   localparam logic [1:0] CMD_IDLE  = 2'h2;
   localparam logic [1:0] CMD_SWSET = 2'h3;
   localparam int DATA1_BITS = NUM_SW - 8;

   // ==========================================================
   // Bit counter landmarks within one byte slot.
   localparam logic [3:0] BIT_ACK  = 4'h8;
   localparam logic [3:0] BIT_POST = 4'h9;

   // Closed and hard-mode bits, one pair per switch.
   typedef struct packed {
      logic [NUM_SW-1:0] closed;
      logic [NUM_SW-1:0] hard;
   } sw_cfg_s;

   localparam sw_cfg_s CFG_RESET = '0;

   // Raw bus and strap pins, kept together for synchronising.
   typedef struct packed {
      logic scl;
      logic sda;
      logic a_hi;
      logic a_lo;
   } pin_s;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_CMD, ST_DATA1, ST_DATA2, ST_DONE, ST_IGNORE
   } rx_state_e;

endpackage

// ==== rtl/pin_sync.sv ====
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Pins are slow levels relative to the core clock.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 4
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] async_i,
   output logic [W-1:0]      sync_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ==========================================================
   // One pair of flops per bit.
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
               meta_q[g] <= 1'h0;
               sync_q[g] <= 1'h0;
            end else begin
               meta_q[g] <= async_i[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_q;

endmodule // pin_sync
`default_nettype wire

// ==== rtl/switch_ramp.sv ====
// Purpose: Drive level of one switch, ramped in soft mode, stepped in hard.
// Assumes: Ticks are one-cycle pulses; gate comes from the array logic.
// Notes:   Flush snaps the level to its current target in one cycle.
`timescale 1ns/1ps
`default_nettype none
module switch_ramp
   import audio_switch_pkg::*;
(
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   input  wire logic             target_i,
   input  wire logic             hard_i,
   input  wire logic             flush_i,
   input  wire logic             gate_i,
   input  wire logic             tick_up_i,
   input  wire logic             tick_dn_i,
   output logic [LVL_W-1:0]      level_o,
   output logic                  opening_o
);

   logic [LVL_W-1:0] level_q;
   logic [LVL_W-1:0] level_d;
   wire  lvl_zero = (level_q == '0);
   wire  lvl_full = (level_q == LVL_MAX);
   wire  go_dn    = !target_i && !lvl_zero;
   wire  go_up    = target_i && !lvl_full && gate_i;
   wire  step_dn  = hard_i || tick_dn_i;
   wire  step_up  = hard_i || tick_up_i;

   // ==========================================================
   // Next level: hard jumps whole, soft moves one step per tick.
   always_comb begin
      level_d = level_q;
      if (flush_i) begin
         level_d = target_i ? LVL_MAX : '0;
      end else if (go_dn && step_dn) begin
         level_d = hard_i ? '0 : level_q - 4'h1;
      end else if (go_up && step_up) begin
         level_d = hard_i ? LVL_MAX : level_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         level_q <= '0;
      end else begin
         level_q <= level_d;
      end
   end

   assign level_o   = level_q;
   assign opening_o = go_dn;

endmodule // switch_ramp
`default_nettype wire

// ==== sim/switch_control_props.sv ====
// Purpose: Port-level assertions for the two-wire switch controller.
// Assumes: Bound to every instance of the top module; sees its ports only.
// Notes:   Ramp checks allow one cycle of slack for the snap-then-load step.
`timescale 1ns/1ps
`default_nettype none
module switch_control_props
   import audio_switch_pkg::*;
(
   input wire logic                    core_clk_i,
   input wire logic                    rst_i,
   input wire logic                    scl_i,
   input wire logic                    sda_i,
   input wire logic                    addr_select_low_i,
   input wire logic                    addr_select_high_i,
   input wire logic                    sda_o,
   input wire logic                    sda_oe_o,
   input wire logic [NUM_SW*LVL_W-1:0] sw_level_o,
   input wire logic [NUM_SW-1:0]       sw_closed_o,
   input wire logic [NUM_SW-1:0]       sw_hard_o,
   input wire logic                    busy_o,
   input wire logic                    cmd_exec_o
);
   // ==========================================================
   // Reset state and command execution.
   a_reset_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $fell(rst_i) |-> sw_closed_o == '0 && sw_hard_o == '0 && !sda_oe_o)
      else $error("outputs not cleared by reset");
   a_exec_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cmd_exec_o |=> !cmd_exec_o)
      else $error("execute pulse longer than one cycle");
   a_exec_in_ack: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cmd_exec_o |-> sda_oe_o)
      else $error("command executed outside an acknowledge clock");
   a_cfg_after_exec: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($changed(sw_closed_o) || $changed(sw_hard_o)) |-> $past(cmd_exec_o))
      else $error("configuration changed without a command");
   // ==========================================================
   // Acknowledge drive: only moves while the clock is low, then stands.
   a_oe_moves_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $changed(sda_oe_o) |-> !scl_i)
      else $error("data line drive changed while clock high");
   a_oe_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(sda_oe_o) |-> sda_oe_o[*4])
      else $error("acknowledge released too early");
   // ==========================================================
   // Opening speed depends on the mode bit of each switch.
   // A switch may only leave zero once no switch of its own mode is still opening.
   // The snap at an executing command is left out, since it finishes every ramp at once.
   logic [NUM_SW-1:0] level_nz;
   for (genvar i = 0; i < NUM_SW; i++) begin : g_sw
      assign level_nz[i] = |sw_level_o[LVL_W*i+:LVL_W];
      a_break_first: assert property (@(posedge core_clk_i)
         disable iff (rst_i)
         !$past(level_nz[i]) && level_nz[i] && !$past(cmd_exec_o) |->
         $past((level_nz & ~sw_closed_o & ~(sw_hard_o ^ {NUM_SW{sw_hard_o[i]}})) == '0))
         else $error("switch closed while a same-mode switch was still opening");
      a_hard_open_fast: assert property (@(posedge core_clk_i)
         disable iff (rst_i)
         $fell(sw_closed_o[i]) && sw_hard_o[i] |-> ##[1:2] sw_level_o[LVL_W*i+:LVL_W] == '0)
         else $error("hard switch did not open at once");
      a_soft_open_slow: assert property (@(posedge core_clk_i)
         disable iff (rst_i)
         $fell(sw_closed_o[i]) && !sw_hard_o[i] |-> ##2 sw_level_o[LVL_W*i+:LVL_W] != '0)
         else $error("soft switch opened without ramping");
   end
endmodule // switch_control_props

bind two_wire_audio_switch_control switch_control_props u_props (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
   .addr_select_low_i(addr_select_low_i), .addr_select_high_i(addr_select_high_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sw_level_o(sw_level_o),
   .sw_closed_o(sw_closed_o), .sw_hard_o(sw_hard_o), .busy_o(busy_o),
   .cmd_exec_o(cmd_exec_o)
);
`default_nettype wire

// ==== sim/bus_master_model.sv ====
// Purpose: Two-wire bus master that writes bytes and reads acknowledges.
// Assumes: 80 ns bus clock: 5 core cycles low, 3 high.
// Notes:   Data moves 2 cycles after a clock fall, clear of the ack release.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input  wire logic core_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // Idle bus: clock parked high, data released; no clock between frames.
   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // Data falls while the clock is high; also serves as a repeated start.
   task automatic start();
      @(posedge core_clk_i);
      sda_low_o <= 1'b0;
      wait_cyc(2);
      scl_o <= 1'b1;
      wait_cyc(3);
      sda_low_o <= 1'b1;
      wait_cyc(3);
      scl_o <= 1'b0;
      wait_cyc(2);
   endtask
   // One clock period; the line level is taken mid-way through the high phase.
   task automatic clock_bit(input logic b, output logic seen);
      sda_low_o <= !b;
      wait_cyc(3);
      scl_o <= 1'b1;
      wait_cyc(2);
      seen = sda_i;
      wait_cyc(1);
      scl_o <= 1'b0;
      wait_cyc(2);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
      clock_bit(1'b1, s);
      ack = !s;
   endtask
   // Data rises while the clock is high and the bus is free again.
   task automatic stop();
      sda_low_o <= 1'b1;
      wait_cyc(3);
      scl_o <= 1'b1;
      wait_cyc(3);
      sda_low_o <= 1'b0;
      wait_cyc(4);
   endtask
endmodule // bus_master_model
`default_nettype wire

// ==== sim/two_wire_audio_switch_control_tb_top.sv ====
// Purpose: Self-checking bench for the two-wire switch controller.
// Assumes: Short ramp steps (4 and 2 cycles) keep soft transitions brief.
// Notes:   A reference model of closed and hard bits is updated per command.
`timescale 1ns/1ps
`default_nettype none
module two_wire_audio_switch_control_tb_top
   import audio_switch_pkg::*;
;
   logic                    core_clk_i = 1'b0;
   logic                    rst_i      = 1'b1;
   logic                    a_lo       = 1'b0;
   logic                    a_hi       = 1'b0;
   logic                    scl;
   logic                    sda_low;
   logic                    sda_o;
   logic                    sda_oe_o;
   logic [NUM_SW*LVL_W-1:0] sw_level_o;
   logic [NUM_SW-1:0]       sw_closed_o;
   logic [NUM_SW-1:0]       sw_hard_o;
   logic                    busy_o;
   logic                    cmd_exec_o;
   wire                     sda_w;
   int                      n_errors   = 0;
   int                      num_checks = 0;
   int                      n_exec     = 0;
   logic [31:0]             seed       = 32'h0000_0023;
   logic [NUM_SW-1:0]       exp_closed = '0;
   logic [NUM_SW-1:0]       exp_hard   = '0;

   // ==========================================================
   // Clock, open-drain data line with pull-up, and parts.
   always #5 core_clk_i = ~core_clk_i;
   assign sda_w = !(sda_low || (sda_oe_o && !sda_o));
   always @(posedge core_clk_i) if (cmd_exec_o === 1'b1) n_exec++;

   two_wire_audio_switch_control #(.ON_STEP(4), .OFF_STEP(2)) dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
      .addr_select_low_i(a_lo), .addr_select_high_i(a_hi), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .sw_level_o(sw_level_o), .sw_closed_o(sw_closed_o),
      .sw_hard_o(sw_hard_o), .busy_o(busy_o), .cmd_exec_o(cmd_exec_o));
   bus_master_model m (.core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl),
      .sda_low_o(sda_low));

   // ==========================================================
   // Helpers.
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] adr(input logic h, input logic l);
      return {5'h0D, h, l, 1'h0};
   endfunction
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (n_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Whole frame: start, n bytes from the top of b, stop; ack bit 3 is byte 0.
   task automatic frame(input logic [31:0] b, input int n, output logic [3:0] ack);
      ack = '0;
      m.start();
      for (int i = 0; i < n; i++) m.put_byte(b[31-8*i-:8], ack[3-i]);
      m.stop();
   endtask
   // Waits for ramps to finish, then compares everything with the model.
   task automatic settle();
      logic [NUM_SW*LVL_W-1:0] lv;
      int t;
      t = 0;
      while (busy_o !== 1'b0 && t < 1000) begin
         @(posedge core_clk_i);
         t++;
      end
      repeat (2) @(posedge core_clk_i);
      check("busy", busy_o, 1'b0);
      for (int i = 0; i < NUM_SW; i++) lv[LVL_W*i+:LVL_W] = exp_closed[i] ? 4'hF : 4'h0;
      check("switch levels", sw_level_o, lv);
      check("closed bits", sw_closed_o, exp_closed);
      check("hard bits", sw_hard_o, exp_hard);
   endtask

   // ==========================================================
   // Main sequence.
   initial begin
      logic [3:0] ack;
      logic [1:0] code;
      int ne;
      repeat (12) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      settle();
      // Word commands at random straps; some follow one another back to back.
      for (int k = 0; k < 12; k++) begin
         seed = xs(seed);
         a_lo <= seed[20];
         a_hi <= seed[21];
         code = (k % 4 == 2) ? CMD_IDLE : (k[0] ? CMD_SWSET : CMD_MODE);
         ne = n_exec;
         frame({adr(seed[21], seed[20]), code, seed[29:24], seed[15:0]}, 4, ack);
         check("word acks", ack, 4'hF);
         check("exec count", n_exec - ne, 1);
         if (code == CMD_MODE) exp_hard = seed[13:0];
         if (code == CMD_SWSET) exp_closed = seed[13:0];
         if (k % 3 != 1) settle();
      end
      // Every address bit wrong in turn, the write bit included.
      ne = n_exec;
      for (int i = 0; i < 8; i++) begin
         frame({adr(a_hi, a_lo) ^ (8'h01 << i), 8'hFF, 16'hFFFF}, 4, ack);
         check("foreign address acks", ack, 4'h0);
      end
      // Aborted after the first data byte.
      frame({adr(a_hi, a_lo), 8'hC0, 8'hFF, 8'h00}, 3, ack);
      check("abort acks", ack, 4'hE);
      check("exec count", n_exec - ne, 0);
      settle();
      // Reset command with a trailing byte that must not be acknowledged.
      frame({adr(a_hi, a_lo), 8'h3F, 8'hFF, 8'h00}, 3, ack);
      check("reset acks", ack, 4'hC);
      check("exec count", n_exec - ne, 1);
      exp_closed = '0;
      exp_hard = '0;
      settle();
      complete_run();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (40000) @(posedge core_clk_i);
      check("watchdog", 64'h0, 64'h1);
      complete_run();
   end
endmodule // two_wire_audio_switch_control_tb_top
`default_nettype wire
